// ===== logic/scm_defs.vh
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SCM_ADDR_MODE 16'hFF60
`define SCM_ADDR_BUSCTL 16'hFF61
`define SCM_ADDR_CLKSEL 16'hFF43

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCM_RST_MODE 8'h00
`define SCM_RST_BUSCTL 8'h00
`define SCM_RST_CLKSEL 8'h88

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define SCM_MODE_ENABLE 7
`define SCM_MODE_MATCH 6
`define SCM_MODE_WAKEUP 5
`define SCM_MODE_SEL_HI 4
`define SCM_MODE_SEL_LO 3
`define SCM_MODE_LINE 2
`define SCM_MODE_CLK_HI 1
`define SCM_MODE_CLK_LO 0

// ----------------------------------------------------------------
// Bus control register fields
// ----------------------------------------------------------------
`define SCM_BUS_BUSY_EN 7
`define SCM_BUS_ACK_DET 6
`define SCM_BUS_ACK_AUTO 5
`define SCM_BUS_ACK_TRIG 4
`define SCM_BUS_CMD_DET 3
`define SCM_BUS_REL_DET 2
`define SCM_BUS_CMD_TRIG 1
`define SCM_BUS_REL_TRIG 0

// ----------------------------------------------------------------
// Clock divider selection codes
// ----------------------------------------------------------------
`define SCM_DIV_SEL_MIN 4'h6
`define SCM_DIV_SEL_MAX 4'hD
`define SCM_DIV_SEL_BIAS 4'h5

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define SCM_OPMODE_3WIRE 2'h0
`define SCM_OPMODE_BUS 2'h2
`define SCM_OPMODE_2WIRE 2'h3

`endif

// ===== logic/scm_word_buffer.v
`timescale 1ns/1ps

module scm_word_buffer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Filling side
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output reg inReady,
  // Draining side
  output reg outValid,
  output reg [WIDTH-1:0] outData,
  input wire outReady
);

  reg [WIDTH-1:0] tailData_reg;
  reg tailValid_reg;
  wire accept;
  wire pop;

  assign accept = inValid & inReady;
  assign pop = outValid & outReady;

  // ----------------------------------------------------------------
  // Head and tail storage.
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
      tailData_reg <= {WIDTH{1'b0}};
      tailValid_reg <= 1'b0;
      inReady <= 1'b1;
    end else begin
      if (pop) begin
        if (tailValid_reg) begin
          outData <= tailData_reg;
          tailValid_reg <= 1'b0;
          inReady <= 1'b1;
        end else begin
          outValid <= accept;
          if (accept) begin
            outData <= inData;
          end
        end
      end else if (accept) begin
        if (!outValid) begin
          outValid <= 1'b1;
          outData <= inData;
        end else begin
          tailData_reg <= inData;
          tailValid_reg <= 1'b1;
          inReady <= 1'b0;
        end
      end
    end
  end

endmodule

// ===== logic/scm_serial_channel_mode_control.v
// Functional notes
// - Reset loads the mode register with zero.
// - All three registers accept single-bit writes and whole-byte writes.
// - Clock bit 1 low picks the pin; high picks timer or divider by bit 0.
// - Divided clock rate follows the low nibble of the clock select register.
// - Bus and 2-wire modes make the data line open-drain; 2-wire also the clock.
// - 3-wire transmit-only use frees the serial input pin as a port.
// - In bus and 2-wire modes the unused data pin stays a port pin.
// - Wake-up low raises the interrupt after every completed transfer.
// - Wake-up high in bus mode interrupts on a matching address after release and command detection, or on a bus release if release interrupt select is set.
// - Match flag is one when slave address equals shift data.
// - Match flag is read-only; writes to bit 6 are ignored.
// - Match flag is zero whenever the channel is disabled.
// - Enable low stops the channel; enable high lets it run.
// - Reset clears the bus control register.
// - Release trigger sets the output latch, then clears itself.
// - Release trigger is held at zero while the channel is disabled.
// - Command trigger clears the output latch, then clears itself.
// - In bus mode, a bus release seen on the bus sets the release detected flag.
// - A received address matching the slave address sets the match flag.
`timescale 1ns/1ps
`include "scm_defs.vh"

module scm_serial_channel_mode_control #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [15:0] regAddr,
  input wire regByteWrite,
  input wire regBitWrite,
  input wire [2:0] regBitIndex,
  input wire regBitValue,
  input wire [7:0] regWriteData,
  input wire regRead,
  output reg [7:0] regReadData,
  // Shift path and bus events
  input wire [WIDTH-1:0] serialShiftRegister,
  input wire [WIDTH-1:0] slaveAddressRegister,
  input wire releaseInterruptSelect,
  input wire transmitOnly,
  input wire transferStart,
  input wire transferDone,
  input wire addressReceived,
  input wire busReleaseSeen,
  input wire commandSeen,
  input wire ackSeen,
  // Clock sources
  input wire serialClockPinN,
  input wire eightBitTimerOutput,
  // Received words
  output wire shiftReady,
  output wire rxValid,
  output wire [WIDTH-1:0] rxData,
  input wire rxReady,
  // Channel state and pin roles
  output reg channelEnable,
  output reg [1:0] operatingMode,
  output reg serialClockTick,
  output reg serialOutLatch,
  output reg interruptRequest,
  output reg ackTriggerPulse,
  output reg busLineAOut,
  output reg busLineAOe,
  output reg busLineAOpenDrain,
  output reg busLineBOut,
  output reg busLineBOe,
  output reg busLineBOpenDrain,
  output reg clockPinOpenDrain,
  output reg serialInPortFree,
  output reg busLineAPortFree,
  output reg busLineBPortFree
);

  reg [7:0] mode_reg;
  reg [7:0] mode_next;
  reg [7:0] busCtl_reg;
  reg [7:0] busCtl_next;
  reg [7:0] clkSel_reg;
  reg [7:0] clkSel_next;
  reg addressMatch_reg;
  reg releaseTrig_reg;
  reg commandTrig_reg;
  reg releaseDet_reg;
  reg commandDet_reg;
  reg ackDet_reg;
  reg pinPrev_reg;
  reg [7:0] divCount_reg;
  reg [7:0] divMask;
  reg divTick;
  reg sourceTick;
  reg [7:0] writeMask;
  reg [7:0] writeValue;
  reg irqEvent;

  wire hitMode;
  wire hitBus;
  wire hitClk;
  wire anyWrite;
  wire enable;
  wire busMode;
  wire twoWireMode;
  wire threeWireMode;
  wire lineA;
  wire compareEqual;
  wire pinFall;

  assign anyWrite = regByteWrite | regBitWrite;
  assign hitMode = regAddr == `SCM_ADDR_MODE;
  assign hitBus = regAddr == `SCM_ADDR_BUSCTL;
  assign hitClk = regAddr == `SCM_ADDR_CLKSEL;
  assign enable = mode_reg[`SCM_MODE_ENABLE];
  assign busMode = mode_reg[`SCM_MODE_SEL_HI:`SCM_MODE_SEL_LO] == `SCM_OPMODE_BUS;
  assign twoWireMode = mode_reg[`SCM_MODE_SEL_HI:`SCM_MODE_SEL_LO] == `SCM_OPMODE_2WIRE;
  assign threeWireMode = ~mode_reg[`SCM_MODE_SEL_HI];
  assign lineA = mode_reg[`SCM_MODE_LINE];
  assign compareEqual = slaveAddressRegister == serialShiftRegister;
  assign pinFall = pinPrev_reg & ~serialClockPinN;

  // ----------------------------------------------------------------
  // Write mask and value for bit and byte accesses.
  // ----------------------------------------------------------------
  always @* begin
    if (regByteWrite) begin
      writeMask = 8'hFF;
      writeValue = regWriteData;
    end else if (regBitWrite) begin
      writeMask = 8'h01 << regBitIndex;
      writeValue = {8{regBitValue}};
    end else begin
      writeMask = 8'h00;
      writeValue = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Next register contents.
  // ----------------------------------------------------------------
  always @* begin
    mode_next = mode_reg;
    busCtl_next = busCtl_reg;
    clkSel_next = clkSel_reg;
    if (anyWrite && hitMode) begin
      mode_next = (mode_reg & ~writeMask) | (writeValue & writeMask);
    end
    if (anyWrite && hitBus) begin
      busCtl_next = (busCtl_reg & ~writeMask) | (writeValue & writeMask);
    end
    if (anyWrite && hitClk) begin
      clkSel_next = (clkSel_reg & ~writeMask) | (writeValue & writeMask);
    end
    mode_next[`SCM_MODE_MATCH] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Stored control registers.
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg <= `SCM_RST_MODE;
      busCtl_reg <= `SCM_RST_BUSCTL;
      clkSel_reg <= `SCM_RST_CLKSEL;
    end else begin
      mode_reg <= mode_next;
      busCtl_reg <= busCtl_next;
      clkSel_reg <= clkSel_next;
    end
  end

  // ----------------------------------------------------------------
  // Trigger bits and serial output latch.
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      releaseTrig_reg <= 1'b0;
      commandTrig_reg <= 1'b0;
      serialOutLatch <= 1'b0;
      ackTriggerPulse <= 1'b0;
    end else begin
      ackTriggerPulse <= enable & anyWrite & hitBus & writeMask[`SCM_BUS_ACK_TRIG]
        & writeValue[`SCM_BUS_ACK_TRIG];
      if (!enable) begin
        releaseTrig_reg <= 1'b0;
        commandTrig_reg <= 1'b0;
      end else begin
        releaseTrig_reg <= anyWrite & hitBus & writeMask[`SCM_BUS_REL_TRIG]
          & writeValue[`SCM_BUS_REL_TRIG];
        commandTrig_reg <= anyWrite & hitBus & writeMask[`SCM_BUS_CMD_TRIG]
          & writeValue[`SCM_BUS_CMD_TRIG];
      end
      if (releaseTrig_reg) begin
        serialOutLatch <= 1'b1;
      end else if (commandTrig_reg) begin
        serialOutLatch <= 1'b0;
      end else if (enable && busMode && transferDone) begin
        serialOutLatch <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Detection flags and address comparison.
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      releaseDet_reg <= 1'b0;
      commandDet_reg <= 1'b0;
      ackDet_reg <= 1'b0;
      addressMatch_reg <= 1'b0;
    end else if (!enable) begin
      releaseDet_reg <= 1'b0;
      commandDet_reg <= 1'b0;
      ackDet_reg <= 1'b0;
      addressMatch_reg <= 1'b0;
    end else begin
      if (busMode && busReleaseSeen) begin
        releaseDet_reg <= 1'b1;
      end else if (transferStart || (addressReceived && !compareEqual)) begin
        releaseDet_reg <= 1'b0;
      end
      if (busMode && commandSeen) begin
        commandDet_reg <= 1'b1;
      end else if (transferStart || busReleaseSeen) begin
        commandDet_reg <= 1'b0;
      end
      if (busMode && ackSeen) begin
        ackDet_reg <= 1'b1;
      end else if (transferStart) begin
        ackDet_reg <= 1'b0;
      end
      addressMatch_reg <= compareEqual;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request generation.
  // ----------------------------------------------------------------
  always @* begin
    if (mode_reg[`SCM_MODE_WAKEUP] && busMode) begin
      irqEvent = (addressReceived & compareEqual & releaseDet_reg & commandDet_reg)
        | (releaseInterruptSelect & busReleaseSeen);
    end else begin
      irqEvent = transferDone;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      interruptRequest <= 1'b0;
    end else begin
      interruptRequest <= enable & irqEvent;
    end
  end

  // ----------------------------------------------------------------
  // Serial clock source selection.
  // ----------------------------------------------------------------
  always @* begin
    divMask = 8'h00;
    divTick = 1'b0;
    if (clkSel_reg[3:0] >= `SCM_DIV_SEL_MIN && clkSel_reg[3:0] <= `SCM_DIV_SEL_MAX) begin
      divMask = ~(8'hFF << (clkSel_reg[3:0] - `SCM_DIV_SEL_BIAS));
      divTick = (divCount_reg & divMask) == divMask;
    end
    if (!mode_reg[`SCM_MODE_CLK_HI]) begin
      sourceTick = pinFall;
    end else if (!mode_reg[`SCM_MODE_CLK_LO]) begin
      sourceTick = eightBitTimerOutput;
    end else begin
      sourceTick = divTick;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pinPrev_reg <= 1'b1;
      divCount_reg <= 8'h00;
      serialClockTick <= 1'b0;
    end else begin
      pinPrev_reg <= serialClockPinN;
      if (!enable) begin
        divCount_reg <= 8'h00;
      end else begin
        divCount_reg <= divCount_reg + 8'h01;
      end
      serialClockTick <= enable & sourceTick;
    end
  end

  // ----------------------------------------------------------------
  // Pin roles per operating mode.
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      channelEnable <= 1'b0;
      operatingMode <= `SCM_OPMODE_3WIRE;
      busLineAOut <= 1'b0;
      busLineAOe <= 1'b0;
      busLineAOpenDrain <= 1'b0;
      busLineBOut <= 1'b0;
      busLineBOe <= 1'b0;
      busLineBOpenDrain <= 1'b0;
      clockPinOpenDrain <= 1'b0;
      serialInPortFree <= 1'b1;
      busLineAPortFree <= 1'b1;
      busLineBPortFree <= 1'b1;
    end else begin
      channelEnable <= enable;
      operatingMode <= mode_reg[`SCM_MODE_SEL_HI:`SCM_MODE_SEL_LO];
      busLineAOut <= 1'b0;
      busLineBOut <= serialOutLatch;
      busLineAOe <= 1'b0;
      busLineBOe <= 1'b0;
      busLineAOpenDrain <= 1'b0;
      busLineBOpenDrain <= 1'b0;
      clockPinOpenDrain <= enable & twoWireMode;
      serialInPortFree <= ~enable | ~threeWireMode | transmitOnly;
      busLineAPortFree <= ~enable;
      busLineBPortFree <= ~enable;
      if (enable && threeWireMode) begin
        busLineBOe <= 1'b1;
      end else if (enable) begin
        if (lineA) begin
          busLineAOpenDrain <= 1'b1;
          busLineAOe <= ~serialOutLatch;
          busLineBPortFree <= 1'b1;
        end else begin
          busLineBOpenDrain <= 1'b1;
          busLineBOut <= 1'b0;
          busLineBOe <= ~serialOutLatch;
          busLineAPortFree <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read-back.
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      if (hitMode) begin
        regReadData <= {mode_reg[7], addressMatch_reg, mode_reg[5:0]};
      end else if (hitBus) begin
        regReadData <= {busCtl_reg[`SCM_BUS_BUSY_EN], ackDet_reg,
          busCtl_reg[`SCM_BUS_ACK_AUTO], 1'b0, commandDet_reg, releaseDet_reg,
          commandTrig_reg, releaseTrig_reg};
      end else if (hitClk) begin
        regReadData <= clkSel_reg;
      end else begin
        regReadData <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Received word buffer.
  // ----------------------------------------------------------------
  scm_word_buffer #(
    .WIDTH(WIDTH)
  ) rxBuffer (
    .clock(clock),
    .rst(rst),
    .inValid(enable & transferDone),
    .inData(serialShiftRegister),
    .inReady(shiftReady),
    .outValid(rxValid),
    .outData(rxData),
    .outReady(rxReady)
  );

endmodule

// ===== verif/scm_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module scm_props (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register port
  input wire [15:0] regAddr,
  input wire regByteWrite,
  input wire regBitWrite,
  input wire [2:0] regBitIndex,
  input wire regBitValue,
  input wire [7:0] regWriteData,
  // Events
  input wire transferDone,
  input wire addressReceived,
  input wire busReleaseSeen,
  // Channel state
  input wire channelEnable,
  input wire [1:0] operatingMode,
  input wire serialClockTick,
  input wire serialOutLatch,
  input wire interruptRequest,
  input wire busLineAOpenDrain,
  input wire busLineBOpenDrain,
  input wire clockPinOpenDrain,
  input wire busLineAPortFree
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire trigWr = regBitWrite && !regByteWrite && regAddr == 16'hFF61 && regBitValue;
  wire evAny = transferDone || addressReceived || busReleaseSeen;
  property p_enable;
    regByteWrite && regAddr == 16'hFF60 |-> ##2 channelEnable == $past(regWriteData[7], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("enable copy wrong");
  property p_irq_cause;
    interruptRequest |-> $past(evAny);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
  property p_irq_done;
    transferDone && channelEnable && $past(channelEnable) && operatingMode == 2'h0
      |=> interruptRequest;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("no interrupt after transfer");
  property p_release;
    trigWr && regBitIndex == 3'h0 && channelEnable |-> ##2 serialOutLatch;
  endproperty
  a_release: assert property (p_release) else $error("release did not set latch");
  property p_command;
    trigWr && regBitIndex == 3'h1 && channelEnable |-> ##2 !serialOutLatch;
  endproperty
  a_command: assert property (p_command) else $error("command did not clear latch");
  property p_release_off;
    trigWr && regBitIndex == 3'h0 && !channelEnable && !$past(channelEnable) && !serialOutLatch
      |=> ##1 !serialOutLatch;
  endproperty
  a_release_off: assert property (p_release_off) else $error("release while off");
  property p_stopped;
    !channelEnable && !$past(channelEnable) |-> !serialClockTick && !interruptRequest;
  endproperty
  a_stopped: assert property (p_stopped) else $error("activity while stopped");
  property p_two_wire;
    channelEnable && operatingMode == 2'h3 && $past(operatingMode) == 2'h3 |-> clockPinOpenDrain;
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("clock pin not open drain");
  property p_line_roles;
    channelEnable && operatingMode[1] && $past(operatingMode) == operatingMode
      |-> busLineAOpenDrain != busLineBOpenDrain && busLineAPortFree == !busLineAOpenDrain;
  endproperty
  a_line_roles: assert property (p_line_roles) else $error("data line roles wrong");
endmodule

// ===== verif/scm_peer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side serial peer
// ----------------------------------------------------------------
module scm_peer (
  // Clock
  input wire clock,
  // Receive stall
  input wire stall,
  // Serial side
  output reg serialClockPinN,
  output reg [7:0] serialShiftRegister,
  output reg [4:0] events,
  output wire rxReady
);
  integer k;
  assign rxReady = !stall;
  initial begin
    serialClockPinN = 1'b1;
    serialShiftRegister = 8'h00;
    events = 5'h00;
  end
  // Pulses start, done, address, release and command for one cycle.
  task ev(input [4:0] m);
    begin
      @(negedge clock) events = m;
      @(negedge clock) events = 5'h00;
    end
  endtask
  // The clock pin idles high and falls eight times within a frame only.
  task frame(input [7:0] w);
    begin
      ev(5'h10);
      for (k = 0; k < 8; k = k + 1) begin
        @(negedge clock) serialClockPinN = 1'b0;
        @(negedge clock) serialClockPinN = 1'b1;
      end
      serialShiftRegister = w;
      ev(5'h08);
    end
  endtask
endmodule

// ===== verif/tb_scm_serial_channel_mode_control.sv
`timescale 1ns/1ps
module tb_scm_serial_channel_mode_control;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [15:0] regAddr = 16'h0000;
  reg [2:0] regBitIndex = 3'h0;
  reg [7:0] regWriteData = 8'h00;
  reg [7:0] slaveAddr = 8'hFF;
  reg regByteWrite = 1'b0;
  reg regBitWrite = 1'b0;
  reg regBitValue = 1'b0;
  reg regRead = 1'b0;
  reg timerTick = 1'b0;
  reg stall = 1'b0;
  reg relSel = 1'b0, txOnly = 1'b0, ackIn = 1'b0;
  wire [1:0] operatingMode;
  wire channelEnable, serialInPortFree, busLineAPortFree, ackTriggerPulse, busLineAOe, busLineBOe;
  reg [7:0] got [0:7];
  wire [7:0] regReadData, rxData, shiftData;
  wire [4:0] ev;
  wire pinN, rxReady, shiftReady, rxValid, serialClockTick, serialOutLatch, interruptRequest;
  wire busLineAOpenDrain, busLineBOpenDrain, clockPinOpenDrain, busLineBPortFree;
  integer fail_count = 0, n_tests = 0, cyc = 0, ticks = 0, irqs = 0, nGot = 0;
  integer c, t0, i0;
  always #4 clock = ~clock;
  scm_serial_channel_mode_control i_scm_serial_channel_mode_control (
    .clock, .rst, .regAddr, .regByteWrite, .regBitWrite, .regBitIndex, .regBitValue,
    .regWriteData, .regRead, .regReadData, .serialShiftRegister(shiftData),
    .slaveAddressRegister(slaveAddr), .releaseInterruptSelect(relSel),
    .transmitOnly(txOnly), .transferStart(ev[4]), .transferDone(ev[3]), .addressReceived(ev[2]),
    .busReleaseSeen(ev[1]), .commandSeen(ev[0]), .ackSeen(ackIn), .serialClockPinN(pinN),
    .eightBitTimerOutput(timerTick), .shiftReady, .rxValid, .rxData, .rxReady,
    .channelEnable, .operatingMode, .serialClockTick, .serialOutLatch, .interruptRequest,
    .ackTriggerPulse, .busLineAOut(), .busLineAOe, .busLineAOpenDrain, .busLineBOut(),
    .busLineBOe, .busLineBOpenDrain, .clockPinOpenDrain, .serialInPortFree,
    .busLineAPortFree, .busLineBPortFree);
  scm_peer i_scm_peer (.clock, .stall, .serialClockPinN(pinN), .serialShiftRegister(shiftData),
    .events(ev), .rxReady);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_of_test;
    begin
      if (fail_count == 0 && n_tests > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  task cmp(input [15:0] g, input [15:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(negedge clock) {regAddr, regWriteData, regByteWrite} = {a, d, 1'b1};
      @(negedge clock) regByteWrite = 1'b0;
    end
  endtask
  task bw(input [15:0] a, input [2:0] i, input v);
    begin
      @(negedge clock) {regAddr, regBitIndex, regBitValue, regBitWrite} = {a, i, v, 1'b1};
      @(negedge clock) regBitWrite = 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(negedge clock) {regAddr, regRead} = {a, 1'b1};
      @(negedge clock) regRead = 1'b0;
      cmp(regReadData, e);
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (serialClockTick === 1'b1) ticks <= ticks + 1;
    if (interruptRequest === 1'b1) irqs <= irqs + 1;
    if (rxValid === 1'b1 && rxReady) begin
      got[nGot] <= rxData;
      nGot <= nGot + 1;
    end
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    rd(16'hFF60, 8'h00);
    rd(16'hFF61, 8'h00);
    rd(16'hFF43, 8'h88);
    rd(16'hFF50, 8'h00);
    wr(16'hFF60, 8'h40);
    rd(16'hFF60, 8'h00);
    bw(16'hFF60, 3'h6, 1'b1);
    rd(16'hFF60, 8'h00);
    bw(16'hFF61, 3'h0, 1'b1);
    repeat (2) @(negedge clock);
    cmp(serialOutLatch, 0);
    rd(16'hFF61, 8'h00);
    bw(16'hFF60, 3'h1, 1'b1);
    bw(16'hFF60, 3'h0, 1'b1);
    rd(16'hFF60, 8'h03);
    for (c = 5; c < 15; c = c + 1) begin
      bw(16'hFF60, 3'h7, 1'b0);
      wr(16'hFF43, c);
      bw(16'hFF60, 3'h7, 1'b1);
      repeat (300) @(negedge clock);
      t0 = ticks;
      repeat (512) @(negedge clock);
      cmp(ticks - t0, (c > 5 && c < 14) ? 512 >> (c - 5) : 0);
    end
    bw(16'hFF60, 3'h7, 1'b0);
    bw(16'hFF60, 3'h0, 1'b0);
    bw(16'hFF60, 3'h7, 1'b1);
    t0 = ticks;
    repeat (5) begin
      @(negedge clock) timerTick = 1'b1;
      @(negedge clock) timerTick = 1'b0;
    end
    repeat (3) @(negedge clock);
    cmp(ticks - t0, 5);
    bw(16'hFF60, 3'h7, 1'b0);
    bw(16'hFF60, 3'h1, 1'b0);
    bw(16'hFF60, 3'h7, 1'b1);
    t0 = ticks;
    i0 = irqs;
    i_scm_peer.frame(8'hA5);
    repeat (3) @(negedge clock);
    cmp(ticks - t0, 8);
    cmp(irqs - i0, 1);
    cmp(got[0], 8'hA5);
    cmp({busLineBOe, busLineAOe, serialInPortFree}, 3'h4);
    @(negedge clock) txOnly = 1'b1;
    repeat (2) @(negedge clock);
    cmp(serialInPortFree, 1);
    txOnly = 1'b0;
    stall = 1'b1;
    i_scm_peer.frame(8'h3C);
    i_scm_peer.frame(8'hC3);
    repeat (3) @(negedge clock);
    cmp(shiftReady, 0);
    stall = 1'b0;
    repeat (4) @(negedge clock);
    cmp({got[1], got[2]}, 16'h3CC3);
    cmp({shiftReady, rxValid, nGot[5:0]}, 8'h83);
    bw(16'hFF61, 3'h0, 1'b1);
    repeat (2) @(negedge clock);
    cmp(serialOutLatch, 1);
    rd(16'hFF61, 8'h00);
    bw(16'hFF61, 3'h1, 1'b1);
    repeat (2) @(negedge clock);
    cmp(serialOutLatch, 0);
    bw(16'hFF60, 3'h7, 1'b0);
    wr(16'hFF60, 8'h34);
    wr(16'hFF60, 8'hB4);
    repeat (2) @(negedge clock);
    cmp({busLineAOpenDrain, busLineBPortFree, busLineAOe}, 3'h7);
    cmp({channelEnable, operatingMode}, 3'h6);
    bw(16'hFF61, 3'h4, 1'b1);
    cmp(ackTriggerPulse, 1);
    @(negedge clock) cmp(ackTriggerPulse, 0);
    slaveAddr = 8'h5A;
    i0 = irqs;
    i_scm_peer.frame(8'h5A);
    rd(16'hFF60, 8'hF4);
    i_scm_peer.ev(5'h02);
    rd(16'hFF61, 8'h04);
    @(negedge clock) ackIn = 1'b1;
    @(negedge clock) ackIn = 1'b0;
    rd(16'hFF61, 8'h44);
    i_scm_peer.ev(5'h01);
    i_scm_peer.ev(5'h04);
    repeat (3) @(negedge clock);
    cmp(irqs - i0, 1);
    relSel = 1'b1;
    i0 = irqs;
    i_scm_peer.ev(5'h02);
    repeat (3) @(negedge clock);
    cmp(irqs - i0, 1);
    relSel = 1'b0;
    bw(16'hFF60, 3'h7, 1'b0);
    rd(16'hFF60, 8'h34);
    wr(16'hFF60, 8'h18);
    wr(16'hFF60, 8'h98);
    repeat (2) @(negedge clock);
    cmp({clockPinOpenDrain, busLineBOpenDrain, busLineBPortFree, busLineAPortFree}, 4'hD);
    end_of_test;
  end
endmodule
bind scm_serial_channel_mode_control scm_props i_scm_props (.clock, .rst, .regAddr,
  .regByteWrite, .regBitWrite, .regBitIndex, .regBitValue, .regWriteData, .transferDone,
  .addressReceived, .busReleaseSeen, .channelEnable, .operatingMode, .serialClockTick,
  .serialOutLatch, .interruptRequest, .busLineAOpenDrain, .busLineBOpenDrain,
  .clockPinOpenDrain, .busLineAPortFree);
